// *** design/asd_decoder.sv ***
`timescale 1ns/1ps
module asd_decoder
	import asd_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic rate_select_a,
	input wire logic rate_select_b,
	input wire logic code_width_select,
	input wire logic code_bit_lsb,
	input wire logic code_bit_1,
	input wire logic code_bit_2,
	input wire logic code_bit_msb,
	input wire logic codec_reset,
	output logic code_ready,
	output logic sample_strobe,
	output logic [SAMPLE_W-1:0] pcm_sample,
	output logic [DAC_W-1:0] analog_sample_out,
	output logic sample_valid
);
	logic [DIV_W-1:0] div_r, div_nxt, div_max;
	logic strobe_r, strobe_nxt;
	logic [SYNC_STAGES-1:0] rst_sh_r, rst_sh_nxt;
	logic rst_lat_r, rst_lat_nxt;
	asd_state_t st_r, st_nxt;
	logic [SAMPLE_W-1:0] acc_r, acc_nxt;
	logic [IDX_W-1:0] idx_r, idx_nxt;
	logic [DAC_W-1:0] dac_r, dac_nxt;
	logic vld_r, vld_nxt;
	logic rdy_r, rdy_nxt;
	logic [3:0] code_in, fq_data;
	logic fq_in_ready, fq_valid, fq_pop;
	logic period_start, latch_pt;
	logic [3:0] code;
	logic [STEP_W-1:0] step;
	logic [SAMPLE_W:0] diff;
	logic [IDX_W:0] idx_t;

	// Codes queued ahead of the decoder
	assign code_in = {code_bit_msb, code_bit_2, code_bit_1,
		code_bit_lsb & code_width_select};

	asd_fifo #(.WIDTH(4), .DEPTH(FIFO_DEPTH)) asd_fifo_i (
		.clock(clock),
		.resetn(resetn),
		.in_valid(rdy_r),
		.in_ready(fq_in_ready),
		.in_data(code_in),
		.out_valid(fq_valid),
		.out_ready(fq_pop),
		.out_data(fq_data)
	);

	// Divider and strobe
	always_comb
	begin
		case ({rate_select_a, rate_select_b})
			2'b00: div_max = DIV_W'(DIV_96 - 1);
			2'b01: div_max = DIV_W'(DIV_64 - 1);
			2'b10: div_max = DIV_W'(DIV_48 - 1);
			default: div_max = DIV_W'(DIV_48 - 1);
		endcase
		period_start = (div_r == '0);
		latch_pt = (div_r == DIV_W'(LATCH_POINT));
		div_nxt = (div_r >= div_max) ? '0 : div_r + 1'b1;
		strobe_nxt = (div_nxt < DIV_W'(({1'b0, div_max} + 8'h01) >> 1));
	end

	// Reset synchronized and latched per period
	always_comb
	begin
		rst_sh_nxt = rst_sh_r;
		rst_lat_nxt = rst_lat_r;
		if (period_start)
			rst_sh_nxt = {rst_sh_r[SYNC_STAGES-2:0], codec_reset};
		if (latch_pt)
			rst_lat_nxt = rst_sh_r[SYNC_STAGES-1];
	end

	// Decode datapath
	always_comb
	begin
		code = fq_data;
		step = asd_step(idx_r);
		diff = {2'b00, step >> 3};
		if (code_width_select)
		begin
			if (code[0]) diff = diff + 13'(step >> 2);
			if (code[1]) diff = diff + 13'(step >> 1);
			if (code[2]) diff = diff + 13'(step);
		end
		else
		begin
			if (code[1]) diff = diff + 13'(step >> 1);
			if (code[2]) diff = diff + 13'(step);
		end
		st_nxt = st_r;
		acc_nxt = acc_r;
		idx_nxt = idx_r;
		dac_nxt = dac_r;
		vld_nxt = 1'b0;
		fq_pop = 1'b0;
		rdy_nxt = period_start && fq_in_ready
			&& (st_r == ASD_RUN);
		idx_t = {1'b0, idx_r};
		case (st_r)
			ASD_IDLE:
			begin
				// Stale codes flushed while held
				fq_pop = 1'b1;
				if (latch_pt && !rst_sh_r[SYNC_STAGES-1])
					st_nxt = ASD_RUN;
			end
			ASD_RUN:
			begin
				if (latch_pt && rst_sh_r[SYNC_STAGES-1])
					st_nxt = ASD_IDLE;
				else if (latch_pt && fq_valid)
				begin
					fq_pop = 1'b1;
					// Wrap, no clamp
					if (code[3])
						acc_nxt = acc_r - diff[SAMPLE_W-1:0];
					else
						acc_nxt = acc_r + diff[SAMPLE_W-1:0];
					if (code[2])
						idx_t = idx_t + (code_width_select ?
							7'(2) * {5'h00, code[1:0]} + 7'h02 :
							7'(2) * {6'h00, code[1]} + 7'h02);
					else if (idx_t != '0)
						idx_t = idx_t - 7'h01;
					idx_nxt = (idx_t > {1'b0, IDX_MAX}) ?
						IDX_MAX : idx_t[IDX_W-1:0];
					dac_nxt = acc_nxt[SAMPLE_W-1 -: DAC_W];
					vld_nxt = 1'b1;
				end
			end
			default: st_nxt = ASD_IDLE;
		endcase
		if (rst_lat_r)
		begin
			acc_nxt = SAMPLE_RST;
			idx_nxt = '0;
			dac_nxt = '0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!resetn)
		begin
			div_r <= '0;
			strobe_r <= 1'b0;
			rst_sh_r <= '1;
			rst_lat_r <= 1'b1;
			st_r <= ASD_IDLE;
			acc_r <= SAMPLE_RST;
			idx_r <= '0;
			dac_r <= '0;
			vld_r <= 1'b0;
			rdy_r <= 1'b0;
		end
		else
		begin
			div_r <= div_nxt;
			strobe_r <= strobe_nxt;
			rst_sh_r <= rst_sh_nxt;
			rst_lat_r <= rst_lat_nxt;
			st_r <= st_nxt;
			acc_r <= acc_nxt;
			idx_r <= idx_nxt;
			dac_r <= dac_nxt;
			vld_r <= vld_nxt;
			rdy_r <= rdy_nxt;
		end
	end

	assign code_ready = rdy_r;
	assign sample_strobe = strobe_r;
	assign pcm_sample = acc_r;
	assign analog_sample_out = dac_r;
	assign sample_valid = vld_r;
endmodule

// *** design/asd_fifo.sv ***
`timescale 1ns/1ps
module asd_fifo
	import asd_pkg::*;
#(
	parameter int WIDTH = 4,
	parameter int DEPTH = FIFO_DEPTH
)(
	input wire logic clock,
	input wire logic resetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0] cnt_r, cnt_nxt;
	logic [WIDTH-1:0] dout_r, dout_nxt;
	logic ov_r, ov_nxt;
	logic push, pop;

	always_comb
	begin
		push = in_valid && (cnt_r != (AW+1)'(DEPTH));
		pop = (!ov_r || out_ready) && (cnt_r != '0);
		wp_nxt = push ? wp_r + 1'b1 : wp_r;
		rp_nxt = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		dout_nxt = pop ? mem[rp_r] : dout_r;
		ov_nxt = pop ? 1'b1 : (out_ready ? 1'b0 : ov_r);
	end

	always_ff @(posedge clock)
	begin
		if (push)
			mem[wp_r] <= in_data;
		if (!resetn)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			dout_r <= '0;
			ov_r <= 1'b0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			dout_r <= dout_nxt;
			ov_r <= ov_nxt;
		end
	end

	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = ov_r;
	assign out_data = dout_r;
endmodule

// *** design/asd_pkg.sv ***
package asd_pkg;
	localparam int SAMPLE_W = 12;
	localparam int DAC_W = 10;
	localparam int IDX_W = 6;
	localparam int STEP_W = 11;
	localparam int DIV_96 = 96;
	localparam int DIV_64 = 64;
	localparam int DIV_48 = 48;
	localparam int DIV_W = 7;
	localparam int LATCH_POINT = 2;
	localparam int SYNC_STAGES = 2;
	localparam int FIFO_DEPTH = 16;
	localparam logic [5:0] IDX_MAX = 6'h30;
	localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 12'h000;

	typedef enum logic [1:0] {
		ASD_IDLE = 2'b00,
		ASD_RUN = 2'b01
	} asd_state_t;

	// Step size table, 49 entries
	function automatic logic [10:0] asd_step(input logic [5:0] i);
		logic [10:0] t [0:48];
		t = '{11'h010, 11'h011, 11'h013, 11'h015, 11'h017, 11'h019,
			11'h01C, 11'h01F, 11'h022, 11'h025, 11'h029, 11'h02D,
			11'h032, 11'h037, 11'h03C, 11'h042, 11'h049, 11'h050,
			11'h058, 11'h061, 11'h06B, 11'h076, 11'h082, 11'h08F,
			11'h09D, 11'h0AD, 11'h0BE, 11'h0D1, 11'h0E6, 11'h0FD,
			11'h117, 11'h133, 11'h151, 11'h173, 11'h198, 11'h1C1,
			11'h1EE, 11'h220, 11'h256, 11'h292, 11'h2D4, 11'h31C,
			11'h36C, 11'h3C3, 11'h424, 11'h48E, 11'h502, 11'h583,
			11'h610};
		return (i > IDX_MAX) ? t[48] : t[i];
	endfunction
endpackage

// *** verif/adpcm_speech_decoder_test.sv ***
`timescale 1ns/1ps
module adpcm_speech_decoder_test;
	import asd_pkg::*;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic rsa = 1'b0;
	logic rsb = 1'b0;
	logic w4 = 1'b1;
	logic keep = 1'b0;
	logic rreq = 1'b1;
	logic [3:0] code = 4'h0;
	logic [3:0] pins;
	logic creset, cready, strobe, valid;
	logic [SAMPLE_W-1:0] pcm;
	logic [DAC_W-1:0] dac;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #2.5 clock = ~clock;
	asd_decoder asd_decoder_i (.clock(clock), .resetn(resetn),
		.rate_select_a(rsa), .rate_select_b(rsb), .code_width_select(w4),
		.code_bit_lsb(pins[0]), .code_bit_1(pins[1]), .code_bit_2(pins[2]),
		.code_bit_msb(pins[3]), .codec_reset(creset), .code_ready(cready),
		.sample_strobe(strobe), .pcm_sample(pcm), .analog_sample_out(dac),
		.sample_valid(valid));
	asd_ctl_model asd_ctl_model_i (.clock(clock), .sample_strobe(strobe),
		.width4(w4), .keep_lsb(keep), .code(code), .rst_req(rreq),
		.code_pins(pins), .codec_reset(creset));
	task automatic conclude();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(string what, logic [11:0] exp, logic [11:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask
	// Strobe period in clock cycles for one rate setting
	task automatic rate(input logic a, input logic b, input int div);
		realtime t0;
		@(negedge clock);
		rsa = a;
		rsb = b;
		repeat (2) @(posedge strobe);
		t0 = $realtime;
		@(posedge strobe);
		check("period", 12'(div),
			12'(int'(($realtime - t0) / 5.0)));
	endtask
	// First sample after a decoder reset with a steady code
	task automatic decode(input logic wid, input logic [3:0] c,
		input logic [11:0] exp);
		int n;
		@(negedge clock);
		w4 = wid;
		code = c;
		rreq = 1'b1;
		repeat (500) @(negedge clock);
		rreq = 1'b0;
		n = 0;
		while (valid !== 1'b1 && n < 2000)
		begin
			@(negedge clock);
			n++;
		end
		check("latency", 12'h000, 12'(n / 2000));
		check("pcm", exp, pcm);
		check("dac", {2'b00, exp[11:2]}, {2'b00, dac});
	endtask
	// Equal runs of up and down shift codes return to centre
	task automatic shift_run();
		int n;
		decode(1'b0, 4'h0, 12'h002);
		n = 1;
		while (n < 100)
		begin
			@(negedge clock);
			if (valid === 1'b1)
			begin
				n++;
				if (n == 49)
					code = 4'h8;
				if (n == 50)
					check("centre up", 12'h064, pcm);
			end
		end
		check("centre back", 12'h000, pcm);
	endtask
	initial
	begin
		repeat (6) @(negedge clock);
		resetn = 1'b1;
		rate(1'b0, 1'b0, 96);
		rate(1'b0, 1'b1, 64);
		rate(1'b1, 1'b0, 48);
		decode(1'b1, 4'h7, 12'h01E);
		decode(1'b1, 4'h6, 12'h01A);
		decode(1'b1, 4'hF, 12'hFE2);
		keep = 1'b1;
		decode(1'b0, 4'h7, 12'h01A);
		keep = 1'b0;
		decode(1'b0, 4'h6, 12'h01A);
		shift_run();
		conclude();
	end
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			conclude();
		end
	end
endmodule
bind asd_decoder asd_chk asd_chk_i (.clock(clock), .resetn(resetn),
	.codec_reset(codec_reset), .code_ready(code_ready),
	.sample_strobe(sample_strobe), .pcm_sample(pcm_sample),
	.analog_sample_out(analog_sample_out), .sample_valid(sample_valid));

// *** verif/asd_chk_sva.sv ***
`timescale 1ns/1ps
module asd_chk
	import asd_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic codec_reset,
	input wire logic code_ready,
	input wire logic sample_strobe,
	input wire logic [SAMPLE_W-1:0] pcm_sample,
	input wire logic [DAC_W-1:0] analog_sample_out,
	input wire logic sample_valid
);
	logic [9:0] rst_r;
	always_ff @(posedge clock)
		if (!resetn)
			rst_r <= '0;
		else
			rst_r <= !codec_reset ? '0 : rst_r + {9'h0, rst_r != 10'h3FF};
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	a_one_sample: assert property (
		sample_valid |=> !sample_valid [*8])
		else $error("sample pulses too close");
	a_one_take: assert property (
		code_ready |=> !code_ready [*8])
		else $error("code takes too close");
	a_take_high: assert property (
		code_ready |-> sample_strobe)
		else $error("code taken outside strobe high");
	a_valid_high: assert property (
		sample_valid |-> sample_strobe)
		else $error("sample outside strobe high");
	a_dac_top: assert property (
		sample_valid |=> analog_sample_out == pcm_sample[11:2])
		else $error("converter code differs from sample");
	a_reset_holds: assert property (
		rst_r > 10'd400 |-> !sample_valid && pcm_sample == SAMPLE_RST)
		else $error("decoder active in reset");
	a_start_run: assert property (
		$fell(codec_reset) |-> ##[1:800] sample_valid)
		else $error("no decode after release");
	a_strobe_runs: assert property (
		sample_strobe |-> ##[1:96] !sample_strobe)
		else $error("strobe stuck high");
endmodule

// *** verif/asd_ctl_model.sv ***
`timescale 1ns/1ps
module asd_ctl_model (
	input wire logic clock,
	input wire logic sample_strobe,
	input wire logic width4,
	input wire logic keep_lsb,
	input wire logic [3:0] code,
	input wire logic rst_req,
	output logic [3:0] code_pins,
	output logic codec_reset
);
	logic strobe_d = 1'b0;
	initial code_pins = 4'h0;
	initial codec_reset = 1'b1;
	// Changes only at the strobe's leading edge
	always @(posedge clock)
	begin
		strobe_d <= sample_strobe;
		if (sample_strobe && !strobe_d)
		begin
			code_pins <= {code[3:1],
				code[0] & (width4 | keep_lsb)};
			codec_reset <= rst_req;
		end
	end
endmodule
